/* dv/acr_core_model.sv */
// Behavioural analog core answering conversion requests.
// Assumes the code is sampled while the request is still high.
`timescale 1ns/10ps
module acr_core_model (
  // Request side
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [4:0] sel_i,
  // Result side
  output logic [9:0] code_o = 10'h2aa
);
  // ****
  // Core
  // ****
  // Outside a conversion the code toggles, so an early sample shows up.
  always @(posedge clk_i) begin
    if (go_i) begin
      code_o <= {5'h16, sel_i};
    end else begin
      code_o <= ~code_o;
    end
  end
endmodule

/* dv/acr_top_properties.sv */
// Port checks of the converter register block.
// Assumes it is bound into acr_top.
`timescale 1ns/10ps
module acr_top_properties (
  // Watched ports
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic avs_read_i,
  input wire logic avs_readdatavalid_o,
  input wire logic avs_waitrequest_o,
  input wire logic [31:0] avs_readdata_o,
  input wire logic global_irq_en_i,
  input wire logic conv_irq_o,
  input wire logic core_go_o,
  input wire logic [4:0] core_sel_o,
  input wire logic [7:0] pin_raw_i,
  input wire logic [7:0] pin_in_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // ****
  // Checks
  // ****
  chk_ack_one: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("ack longer than one cycle");
  chk_rdv_ack: assert property (avs_readdatavalid_o |-> !avs_waitrequest_o)
    else $error("read data without ack");
  chk_rdv_read: assert property (avs_readdatavalid_o |-> $past(avs_read_i))
    else $error("read data without read");
  chk_upper_zero: assert property (avs_readdatavalid_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_irq_gate: assert property (conv_irq_o |-> $past(global_irq_en_i))
    else $error("irq without global enable");
  chk_pin_mask: assert property ((pin_in_o & ~$past(pin_raw_i)) == 8'h00)
    else $error("pin input not from pin");
  chk_conv_min: assert property ($rose(core_go_o) |=> core_go_o [*8])
    else $error("conversion too short");
  chk_sel_hold: assert property ($rose(core_go_o) |=> $stable(core_sel_o) [*8])
    else $error("selection moved in conversion");
  cover property ($rose(core_go_o));
  cover property ($rose(conv_irq_o));
  cover property (avs_readdatavalid_o);
endmodule
bind acr_top acr_top_properties acr_top_properties_inst (.clk_i(clk_i), .resetn_i(resetn_i),
  .avs_read_i(avs_read_i), .avs_readdatavalid_o(avs_readdatavalid_o),
  .avs_waitrequest_o(avs_waitrequest_o), .avs_readdata_o(avs_readdata_o),
  .global_irq_en_i(global_irq_en_i), .conv_irq_o(conv_irq_o), .core_go_o(core_go_o),
  .core_sel_o(core_sel_o), .pin_raw_i(pin_raw_i), .pin_in_o(pin_in_o));

/* dv/adc_control_and_result_regs_test.sv */
// Self-checking bench for the converter register block.
// Assumes the core model and checker are compiled first.
`timescale 1ns/10ps
module adc_control_and_result_regs_test;
  logic clk = 0, rstn = 0, rd = 0, wr = 0, gie = 0, vt = 0, rdv, wreq, irq, go;
  logic [7:0] adr = 0, trig = 0, praw = 0, v, pin;
  logic [7:0] ra [7] = '{8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7e, 8'h7f};
  logic [31:0] wdat = 0, rdat;
  logic [4:0] sel;
  logic [9:0] code;
  int err_total = 0, cmp_count = 0, cyc = 0, glen = 0, last = 0, dv;
  acr_top acr_top_inst (.clk_i(clk), .resetn_i(rstn), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'h1), .avs_readdata_o(rdat),
    .avs_readdatavalid_o(rdv), .avs_waitrequest_o(wreq), .trig_flags_i(trig),
    .global_irq_en_i(gie), .vector_taken_i(vt), .conv_irq_o(irq), .core_code_i(code),
    .core_go_o(go), .core_sel_o(sel), .pin_raw_i(praw), .pin_in_o(pin));
  acr_core_model acr_core_model_inst (.clk_i(clk), .go_i(go), .sel_i(sel), .code_o(code));
  // ****
  // Tasks
  // ****
  initial forever #20 clk = ~clk;
  // Conversion length is measured at the core request, not by polling.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (go) begin
      glen <= glen + 1;
    end else if (glen != 0) begin
      last <= glen;
      glen <= 0;
    end
    if (cyc == 20000) begin
      err_total++;
      conclude;
    end
  end
  task conclude;
    if (err_total == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task chk(input logic [7:0] s, input logic [7:0] e, input string n);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task acc(input logic w, input logic [7:0] i, input logic [7:0] d);
    @(posedge clk);
    adr <= i;
    rd <= !w;
    wr <= w;
    wdat <= {24'h0, d};
    do @(posedge clk); while (wreq !== 1'b0);
    v = rdat[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task rc(input logic [7:0] i, input logic [7:0] e, input string n);
    acc(1'b0, i, 8'h00);
    chk(v, e, n);
  endtask
  task wdone;
    do acc(1'b0, 8'h7a, 8'h00); while (v[4] !== 1'b1);
    @(posedge clk);
  endtask
  // ****
  // Tests
  // ****
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (ra[i]) begin
      rc(ra[i], 8'h00, "reset value");
    end
    acc(1'b1, 8'h7b, 8'hff);
    rc(8'h7b, 8'h47, "control b");
    praw <= 8'hff;
    acc(1'b1, 8'h7e, 8'ha5);
    @(posedge clk);
    chk(pin, 8'h5a, "pin input");
    gie <= 1'b1;
    acc(1'b1, 8'h7b, 8'h00);
    acc(1'b1, 8'h7c, 8'h03);
    acc(1'b1, 8'h7a, 8'hc8);
    rc(8'h7a, 8'hc8, "busy");
    wdone;
    chk(8'(last >= 50), 8'h01, "first length");
    chk(8'(irq), 8'h01, "irq");
    rc(8'h78, 8'hc3, "low right");
    rc(8'h79, 8'h02, "high right");
    acc(1'b1, 8'h7c, 8'h23);
    rc(8'h78, 8'hc0, "low left");
    rc(8'h79, 8'hb0, "high left");
    for (int d = 0; d < 8; d++) begin
      dv = (d < 2) ? 2 : (1 << d);
      gie <= d[0];
      acc(1'b1, 8'h7a, 8'hd8 | 8'(d));
      wdone;
      chk(8'(last >= 13 * dv && last < 14 * dv + 8), 8'h01, "divider");
      chk(8'(irq), 8'(d[0]), "irq gate");
      vt <= 1'b1;
      @(posedge clk);
      vt <= 1'b0;
      rc(8'h7a, 8'h88 | 8'(d), "vector clear");
    end
    acc(1'b1, 8'h7a, 8'he0);
    wdone;
    acc(1'b0, 8'h78, 8'h00);
    acc(1'b1, 8'h7a, 8'hf0);
    repeat (200) @(posedge clk);
    rc(8'h7a, 8'he0, "locked");
    acc(1'b0, 8'h79, 8'h00);
    repeat (200) @(posedge clk);
    wdone;
    acc(1'b1, 8'h7a, 8'h10);
    repeat (100) @(posedge clk);
    rc(8'h7a, 8'h00, "off");
    acc(1'b1, 8'h7a, 8'h80);
    acc(1'b1, 8'h7b, 8'h02);
    trig <= 8'h04;
    repeat (60) @(posedge clk);
    rc(8'h7a, 8'h80, "no auto");
    acc(1'b1, 8'h7a, 8'ha0);
    for (int k = 1; k < 8; k++) begin
      trig <= 8'h00;
      acc(1'b1, 8'h7b, 8'(k));
      trig <= 8'h01 << k;
      wdone;
      chk(v, 8'hb0, "triggered");
      acc(1'b1, 8'h7a, 8'hb0);
    end
    trig <= 8'h02;
    acc(1'b1, 8'h7b, 8'h01);
    wdone;
    chk(v, 8'hb0, "switch edge");
    acc(1'b1, 8'h7b, 8'h00);
    repeat (60) @(posedge clk);
    rc(8'h7a, 8'hb0, "free no event");
    conclude;
  end
endmodule

/* hdl/acr_cfg.svh */
// Constants of the converter control and result register block.
// Assumes a 32-bit Avalon-MM slave whose 8-bit word address equals the register offset.
// ************************************************************
// ************************************************************
`ifndef ACR_CFG_SVH
`define ACR_CFG_SVH
`define ACR_IDX_RES_LO 8'h78
`define ACR_IDX_RES_HI 8'h79
`define ACR_IDX_CSA 8'h7a
`define ACR_IDX_CSB 8'h7b
`define ACR_IDX_MUX 8'h7c
`define ACR_IDX_DIS 8'h7e
`define ACR_CSA_ON 7
`define ACR_CSA_GO 6
`define ACR_CSA_AUTO 5
`define ACR_CSA_DONE 4
`define ACR_CSA_IRQEN 3
`define ACR_MUX_REF 6
`define ACR_MUX_LEFT 5
`define ACR_CSB_MASK 8'h47
`define ACR_MUX_MASK 8'h6f
`define ACR_CYC_FIRST 8'h19
`define ACR_CYC_NORMAL 8'h0d
`define ACR_RESET_BYTE 8'h00
`endif

/* hdl/acr_pkg.sv */
// Types of the converter control and result register block.
// Assumes the constants header is compiled alongside.
package acr_pkg;
  typedef enum logic [1:0] {ACR_IDLE, ACR_CONV} acr_phase_e;
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [7:0] csa;
    logic [7:0] csb;
    logic [7:0] mux;
    logic [7:0] dis;
    logic [9:0] result;
    logic lock;
    logic first;
    acr_phase_e phase;
    logic [6:0] presc;
    logic [7:0] cyc;
    logic trig_prev;
    logic [4:0] live_sel;
    logic waitreq;
    logic [31:0] rdata;
    logic rdvalid;
    logic irq;
    logic [7:0] pin_in;
    logic [4:0] core_sel;
    logic core_go;
  } acr_state_s;
endpackage

/* hdl/acr_top.sv */
// Converter control, status and result registers around a successive-approximation core.
// Assumes a 25 MHz clock, an Avalon-MM master and an analog core that presents its code at done.
`timescale 1ns/10ps
`include "acr_cfg.svh"
module acr_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Avalon-MM slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_readdatavalid_o,
  output logic avs_waitrequest_o,
  // Trigger flags from peripherals, bit n is source code n for n from 1 to 7; bit 0 is unused
  input wire logic [7:0] trig_flags_i,
  // Interrupt handshake with the CPU
  input wire logic global_irq_en_i,
  input wire logic vector_taken_i,
  output logic conv_irq_o,
  // Analog core
  input wire logic [9:0] core_code_i,
  output logic core_go_o,
  output logic [4:0] core_sel_o,
  // Port pins
  input wire logic [7:0] pin_raw_i,
  output logic [7:0] pin_in_o
);
  // ************************************************************
  // State
  // ************************************************************
  acr_pkg::acr_state_s s;
  acr_pkg::acr_state_s n;
  logic rst_n;
  assign rst_n = s.rst_sync[1];

  function automatic logic [7:0] acr_byte(input logic [31:0] d, input logic [3:0] be, input logic [7:0] old);
    acr_byte = be[0] ? d[7:0] : old;
  endfunction

  function automatic logic acr_tick(input logic [6:0] cnt, input logic [2:0] code);
    logic [6:0] m;
    m = (code <= 3'd1) ? 7'h01 : 7'((8'h01 << code) - 8'h01);
    acr_tick = ((cnt & m) == m);
  endfunction

  always_comb begin
    logic [7:0] idx;
    logic wr;
    logic rd;
    logic [7:0] wb;
    logic trig_now;
    logic start;
    logic done;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] rb;
    logic kill;
    idx = '0;
    wr = 1'b0;
    rd = 1'b0;
    wb = '0;
    trig_now = 1'b0;
    start = 1'b0;
    done = 1'b0;
    hi = '0;
    lo = '0;
    rb = '0;
    kill = 1'b0;
    n = s;
    n.rst_sync = {s.rst_sync[0], 1'b1};
    // The bus carries word addresses, so the address is the register offset itself.
    idx = avs_address_i;
    // Requests are answered in the cycle after they are seen; waitrequest stays high until then.
    wr = avs_write_i && s.waitreq;
    rd = avs_read_i && s.waitreq;
    n.waitreq = !(wr || rd);
    n.rdvalid = rd;
    wb = acr_byte(avs_writedata_i, avs_byteenable_i, 8'h00);
    // A turn-off write in the completing cycle wins, so an aborted conversion never posts a result.
    kill = wr && (idx == `ACR_IDX_CSA) && !wb[`ACR_CSA_ON];
    // Presentation follows the justify bit at once, so read data is built from the stored code.
    if (s.mux[`ACR_MUX_LEFT]) begin
      hi = s.result[9:2];
      lo = {s.result[1:0], 6'h00};
    end else begin
      hi = {6'h00, s.result[9:8]};
      lo = s.result[7:0];
    end
    // ************************************************************
    // Trigger and conversion
    // ************************************************************
    trig_now = (s.csb[2:0] != 3'd0) && trig_flags_i[s.csb[2:0]];
    n.trig_prev = trig_now;
    start = s.csa[`ACR_CSA_ON] && s.csa[`ACR_CSA_AUTO] && trig_now && !s.trig_prev;
    n.presc = 7'(s.presc + 7'd1);
    case (s.phase)
      acr_pkg::ACR_IDLE: begin
        n.cyc = '0;
      end
      acr_pkg::ACR_CONV: begin
        if (!s.csa[`ACR_CSA_ON] || kill) begin
          n.phase = acr_pkg::ACR_IDLE;
          n.csa[`ACR_CSA_GO] = 1'b0;
        end else if (acr_tick(s.presc, s.csa[2:0])) begin
          n.cyc = 8'(s.cyc + 8'd1);
          if (n.cyc == (s.first ? `ACR_CYC_FIRST : `ACR_CYC_NORMAL)) begin
            done = 1'b1;
          end
        end
      end
      default: n.phase = acr_pkg::ACR_IDLE;
    endcase
    n.core_go = (s.phase == acr_pkg::ACR_CONV) && s.csa[`ACR_CSA_ON];
    if (done) begin
      n.first = 1'b0;
      n.phase = acr_pkg::ACR_IDLE;
      n.csa[`ACR_CSA_GO] = 1'b0;
      if (!s.lock) begin
        n.result = core_code_i;
        n.csa[`ACR_CSA_DONE] = 1'b1;
      end
      n.core_sel = s.live_sel;
      // Free running: auto-trigger with code zero restarts on each completion.
      if (s.csa[`ACR_CSA_AUTO] && s.csb[2:0] == 3'd0) begin
        start = 1'b1;
      end
    end
    // ************************************************************
    // Register writes and reads
    // ************************************************************
    if (wr) begin
      case (idx)
        `ACR_IDX_CSA: begin
          n.csa[`ACR_CSA_ON] = wb[`ACR_CSA_ON];
          if (wb[`ACR_CSA_ON] && !s.csa[`ACR_CSA_ON]) begin
            n.first = 1'b1;
          end
          if (!wb[`ACR_CSA_ON]) begin
            n.phase = acr_pkg::ACR_IDLE;
            n.csa[`ACR_CSA_GO] = 1'b0;
            start = 1'b0;
          end
          n.csa[`ACR_CSA_AUTO] = wb[`ACR_CSA_AUTO];
          n.csa[`ACR_CSA_IRQEN] = wb[`ACR_CSA_IRQEN];
          n.csa[2:0] = wb[2:0];
          if (wb[`ACR_CSA_GO] && wb[`ACR_CSA_ON]) begin
            start = 1'b1;
          end
          if (wb[`ACR_CSA_DONE] && !(done && !s.lock)) begin
            n.csa[`ACR_CSA_DONE] = 1'b0;
          end
        end
        `ACR_IDX_CSB: n.csb = wb & `ACR_CSB_MASK;
        `ACR_IDX_MUX: begin
          n.mux = wb & `ACR_MUX_MASK;
          n.live_sel = {wb[`ACR_MUX_REF], wb[3:0]};
        end
        `ACR_IDX_DIS: n.dis = wb;
        default: n.dis = n.dis;
      endcase
    end
    if (vector_taken_i && !(done && !s.lock)) begin
      n.csa[`ACR_CSA_DONE] = 1'b0;
    end
    if (start && (s.phase == acr_pkg::ACR_IDLE || done) && n.csa[`ACR_CSA_ON]) begin
      n.phase = acr_pkg::ACR_CONV;
      n.csa[`ACR_CSA_GO] = 1'b1;
      n.cyc = '0;
      n.presc = '0;
      if (s.phase == acr_pkg::ACR_IDLE) begin
        n.core_sel = n.live_sel;
      end
    end
    if (rd) begin
      case (idx)
        `ACR_IDX_RES_LO: begin
          rb = lo;
          n.lock = 1'b1;
        end
        `ACR_IDX_RES_HI: begin
          rb = hi;
          n.lock = 1'b0;
        end
        `ACR_IDX_CSA: rb = s.csa;
        `ACR_IDX_CSB: rb = s.csb;
        `ACR_IDX_MUX: rb = s.mux;
        `ACR_IDX_DIS: rb = s.dis;
        default: rb = '0;
      endcase
    end
    n.rdata = {24'h00_0000, rb};
    n.irq = n.csa[`ACR_CSA_DONE] && n.csa[`ACR_CSA_IRQEN] && global_irq_en_i;
    n.pin_in = pin_raw_i & ~s.dis;
  end

  // Reset is released through two flip-flops; all other state clears while it is held, except waitrequest, which is set high during the release.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else if (!rst_n) begin
      s <= '0;
      s.rst_sync <= {s.rst_sync[0], 1'b1};
      s.waitreq <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata_o = s.rdata;
  assign avs_readdatavalid_o = s.rdvalid;
  assign avs_waitrequest_o = s.waitreq;
  assign conv_irq_o = s.irq;
  assign core_go_o = s.core_go;
  assign core_sel_o = s.core_sel;
  assign pin_in_o = s.pin_in;
endmodule
